// ---- pkg/dsb_pkg.sv ----
// constants and carrier types for the double-data-rate separate-port burst-of-two sram port
// assumes a single sampling clock well above the rate of the timing pairs it watches
package dsb_pkg;

    // ==========================================================
    // array geometry (wide variant)
    localparam int ADDR_W = 20;
    localparam int WORD_IDX_W = ADDR_W + 1;
    localparam int MEM_WORDS = 2097152;
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int BURST_LEN = 2;

    // ==========================================================
    // burst word selectors (sequential order)
    localparam logic BEAT_FIRST = 1'h0;
    localparam logic BEAT_SECOND = 1'h1;

    // ==========================================================
    // power-up strap capture of single-pair mode
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [1:0] STRAP_STEP = 2'h1;

    // ==========================================================
    // timing figures
    localparam real REF_PERIOD_NS = 25.0;
    localparam real LINK_PERIOD_NS = 200.0;
    localparam int LINK_HALF_CYCLES = int'(LINK_PERIOD_NS / (2.0 * REF_PERIOD_NS));

    // ==========================================================
    // read output phase, one-hot
    typedef enum logic [2:0] {
        OUT_IDLE = 3'h1,
        OUT_WORD0 = 3'h2,
        OUT_WORD1 = 3'h4
    } dsb_phase_t;

    // ==========================================================
    // every pin sampled by the port, travelling through the synchroniser together
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic load_n;
        logic rw;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] bw_n;
        logic loop_n;
    } dsb_pins_t;

    // a pending burst: valid flag and its word-pair address
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } dsb_slot_t;

endpackage : dsb_pkg

// ---- hw/dsb_sram_port.sv ----
// synchronous port logic of a burst-of-two double-data-rate sram with separate read and write ports
// assumes all pins arrive asynchronously to REF_CLK and that REF_CLK runs at least
// eight times faster than the input timing pair
`timescale 1ns/1ps

// How it works
// - command, address and write inputs sampled on input pair rising edges
// - read command latches address into read register
// - each read fetches two consecutive words
// - word0 after next negative input edge, then word1
// - back-to-back reads drive every output edge
// - output pair tied high uses input pair
// - echo strobe pair accompanies read data
// - after burst, deselect at next input rise
// - write command latches address into write register
// - two write words on following input rises
// - load_n high means no new write
// - write bits ignored when write not enabled
// - each active-low lane enable gates nine bits
// - shared address, fixed two-word sequential burst
// - array of 2M words by 36 bits
// - loop_disable_n low disables delay-locked loop
module dsb_sram_port (
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    // timing pairs
    input wire logic K_CLK,
    input wire logic K_CLK_N,
    input wire logic C_CLK,
    input wire logic C_CLK_N,
    // command and address
    input wire logic LOAD_N,
    input wire logic READ_WRITE_SELECT,
    input wire logic [dsb_pkg::ADDR_W-1:0] ADDRESS_PINS,
    // write port
    input wire logic [dsb_pkg::DATA_W-1:0] WRITE_PORT_BITS,
    input wire logic [dsb_pkg::LANES-1:0] BYTE_LANE_WRITE_N,
    // loop control
    input wire logic LOOP_DISABLE_N,
    // read port
    output logic [dsb_pkg::DATA_W-1:0] READ_PORT_BITS,
    output logic READ_PORT_OE,
    output logic [1:0] ECHO_STROBE_PAIR,
    // status
    output logic LOOP_ACTIVE
);

    // ==========================================================
    // lane merge
    function automatic logic [dsb_pkg::DATA_W-1:0] merge_lanes(
        input logic [dsb_pkg::DATA_W-1:0] old_w,
        input logic [dsb_pkg::DATA_W-1:0] new_w,
        input logic [dsb_pkg::LANES-1:0] bw_n
    );
        logic [dsb_pkg::DATA_W-1:0] res;
        res = old_w;
        for (int l = 0; l < dsb_pkg::LANES; l++) begin
            if (!bw_n[l]) begin
                res[l*dsb_pkg::LANE_W +: dsb_pkg::LANE_W] =
                    new_w[l*dsb_pkg::LANE_W +: dsb_pkg::LANE_W];
            end
        end
        return res;
    endfunction : merge_lanes

    // ==========================================================
    // pin synchroniser and edge detection
    dsb_pkg::dsb_pins_t pins_raw;
    dsb_pkg::dsb_pins_t sync1_q;
    dsb_pkg::dsb_pins_t pins_q;
    logic [3:0] clk_prev_q;

    assign pins_raw = '{k: K_CLK, k_n: K_CLK_N, c: C_CLK, c_n: C_CLK_N, load_n: LOAD_N,
                        rw: READ_WRITE_SELECT, addr: ADDRESS_PINS, data: WRITE_PORT_BITS,
                        bw_n: BYTE_LANE_WRITE_N, loop_n: LOOP_DISABLE_N};

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_q <= '0;
            pins_q <= '0;
            clk_prev_q <= '0;
        end else if (CLK_EN) begin
            sync1_q <= pins_raw;
            pins_q <= sync1_q;
            clk_prev_q <= {pins_q.k, pins_q.k_n, pins_q.c, pins_q.c_n};
        end
    end

    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    assign k_rise = pins_q.k & ~clk_prev_q[3];
    assign kn_rise = pins_q.k_n & ~clk_prev_q[2];
    assign c_rise = pins_q.c & ~clk_prev_q[1];
    assign cn_rise = pins_q.c_n & ~clk_prev_q[0];

    // ==========================================================
    // single-pair mode strap, caught once after reset release
    logic [1:0] strap_cnt_q;
    logic single_q;
    logic strap_done;
    assign strap_done = (strap_cnt_q == dsb_pkg::STRAP_WAIT);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_cnt_q <= '0;
            single_q <= 1'h0;
        end else if (CLK_EN && !strap_done) begin
            strap_cnt_q <= strap_cnt_q + dsb_pkg::STRAP_STEP;
            if (strap_cnt_q == dsb_pkg::STRAP_WAIT - dsb_pkg::STRAP_STEP) begin
                single_q <= pins_q.c & pins_q.c_n;
            end
        end
    end

    // output timing edges: output pair, or input pair in single-pair mode
    logic oc_rise;
    logic ocn_rise;
    assign oc_rise = single_q ? k_rise : c_rise;
    assign ocn_rise = single_q ? kn_rise : cn_rise;

    // ==========================================================
    // command decode
    logic rd_cmd;
    logic wr_cmd;
    assign rd_cmd = k_rise & ~pins_q.load_n & pins_q.rw;
    assign wr_cmd = k_rise & ~pins_q.load_n & ~pins_q.rw;

    // ==========================================================
    // memory array and write path
    logic [dsb_pkg::DATA_W-1:0] mem_q [0:dsb_pkg::MEM_WORDS-1];
    dsb_pkg::dsb_slot_t wr0_q;
    dsb_pkg::dsb_slot_t wr1_q;
    logic mem_we;
    logic [dsb_pkg::WORD_IDX_W-1:0] mem_widx;

    always_comb begin
        mem_we = 1'h0;
        mem_widx = '0;
        if (k_rise && wr0_q.valid) begin
            mem_we = 1'h1;
            mem_widx = {wr0_q.addr, dsb_pkg::BEAT_FIRST};
        end else if (kn_rise && wr1_q.valid) begin
            mem_we = 1'h1;
            mem_widx = {wr1_q.addr, dsb_pkg::BEAT_SECOND};
        end
    end

    // each beat lands in the array at once, so a later read always sees it
    always_ff @(posedge REF_CLK) begin
        if (CLK_EN && mem_we) begin
            mem_q[mem_widx] <= merge_lanes(mem_q[mem_widx], pins_q.data, pins_q.bw_n);
        end
    end

    // write slots: first beat on the next K rise, second on the following K# rise
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr0_q <= '0;
            wr1_q <= '0;
        end else if (CLK_EN) begin
            if (k_rise) begin
                wr0_q <= '{valid: wr_cmd, addr: pins_q.addr};
                wr1_q <= wr0_q;
            end else if (kn_rise) begin
                wr1_q.valid <= 1'h0;
            end
        end
    end

    // ==========================================================
    // read pipeline: captured, armed by K#, then driven on output edges
    dsb_pkg::dsb_slot_t rd_a_q;
    dsb_pkg::dsb_slot_t rd_b_q;
    logic [dsb_pkg::ADDR_W-1:0] rd_c_addr_q;
    dsb_pkg::dsb_phase_t phase_q;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_a_q <= '0;
            rd_b_q <= '0;
        end else if (CLK_EN) begin
            if (rd_cmd) begin
                rd_a_q <= '{valid: 1'h1, addr: pins_q.addr};
            end else if (kn_rise) begin
                rd_a_q.valid <= 1'h0;
            end
            if (kn_rise) begin
                rd_b_q <= rd_a_q;
            end else if (ocn_rise) begin
                rd_b_q.valid <= 1'h0;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_q <= dsb_pkg::OUT_IDLE;
            rd_c_addr_q <= '0;
        end else if (CLK_EN) begin
            case (phase_q)
                dsb_pkg::OUT_IDLE: begin
                    if (ocn_rise && rd_b_q.valid) begin
                        phase_q <= dsb_pkg::OUT_WORD0;
                        rd_c_addr_q <= rd_b_q.addr;
                    end
                end
                dsb_pkg::OUT_WORD0: begin
                    if (oc_rise) begin
                        phase_q <= dsb_pkg::OUT_WORD1;
                    end
                end
                dsb_pkg::OUT_WORD1: begin
                    if (ocn_rise && rd_b_q.valid) begin
                        phase_q <= dsb_pkg::OUT_WORD0;
                        rd_c_addr_q <= rd_b_q.addr;
                    end else if (ocn_rise) begin
                        phase_q <= dsb_pkg::OUT_IDLE;
                    end
                end
                default: begin
                    phase_q <= dsb_pkg::OUT_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // read data, enable, echo strobes, loop status
    logic rd_idle;
    assign rd_idle = ~rd_a_q.valid & ~rd_b_q.valid & (phase_q == dsb_pkg::OUT_IDLE);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            READ_PORT_BITS <= '0;
            READ_PORT_OE <= 1'h0;
        end else if (CLK_EN) begin
            if (ocn_rise && rd_b_q.valid) begin
                READ_PORT_BITS <= mem_q[{rd_b_q.addr, dsb_pkg::BEAT_FIRST}];
                READ_PORT_OE <= 1'h1;
            end else if (oc_rise && phase_q == dsb_pkg::OUT_WORD0) begin
                READ_PORT_BITS <= mem_q[{rd_c_addr_q, dsb_pkg::BEAT_SECOND}];
            end else if (k_rise && rd_idle && !rd_cmd) begin
                READ_PORT_OE <= 1'h0;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ECHO_STROBE_PAIR <= '0;
            LOOP_ACTIVE <= 1'h0;
        end else if (CLK_EN) begin
            ECHO_STROBE_PAIR[0] <= single_q ? pins_q.k : pins_q.c;
            ECHO_STROBE_PAIR[1] <= single_q ? pins_q.k_n : pins_q.c_n;
            LOOP_ACTIVE <= pins_q.loop_n;
        end
    end

    // ==========================================================
    // checks
    a_read_capture: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        rd_cmd |=> rd_a_q.valid && rd_a_q.addr == $past(pins_q.addr))
        else $error("read address not captured");

    a_read_arm: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        kn_rise && rd_a_q.valid |=> rd_b_q.valid && rd_b_q.addr == $past(rd_a_q.addr))
        else $error("read not armed on negative input edge");

    a_word0_drive: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        ocn_rise && rd_b_q.valid |=> phase_q == dsb_pkg::OUT_WORD0 && READ_PORT_OE)
        else $error("first read word not driven");

    a_word1_follow: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        phase_q == dsb_pkg::OUT_WORD0 && oc_rise && !ocn_rise
        |=> phase_q == dsb_pkg::OUT_WORD1)
        else $error("second read word not driven");

    a_drive_enabled: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        phase_q != dsb_pkg::OUT_IDLE |-> READ_PORT_OE)
        else $error("read word driven while outputs disabled");

    a_read_deselect: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        k_rise && rd_idle && !rd_cmd && !ocn_rise |=> !READ_PORT_OE)
        else $error("outputs not released after burst");

    a_write_beats: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        k_rise && wr0_q.valid |-> mem_we ##1 (wr1_q.valid && wr1_q.addr == $past(wr0_q.addr)))
        else $error("write beat sequence broken");

    a_write_idle: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        k_rise && pins_q.load_n |=> !wr0_q.valid)
        else $error("write slot filled without load");

    a_write_gate: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        mem_we |-> (k_rise && wr0_q.valid) || (kn_rise && wr1_q.valid))
        else $error("array written outside a write cycle");

    a_single_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        strap_done |=> $stable(single_q))
        else $error("single-pair mode changed after power-up");

    a_echo_rise: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        oc_rise |=> ECHO_STROBE_PAIR[0])
        else $error("echo strobe not following output clock");

    a_loop_status: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        !pins_q.loop_n |=> !LOOP_ACTIVE)
        else $error("loop reported active while disabled");

    a_write_slot: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        wr_cmd |=> wr0_q.valid && wr0_q.addr == $past(pins_q.addr))
        else $error("write address not captured");

    a_second_beat: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        kn_rise && !k_rise && wr1_q.valid
        |-> mem_we && mem_widx == {wr1_q.addr, dsb_pkg::BEAT_SECOND})
        else $error("second write beat not stored");

    a_write_edges: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        !k_rise && !kn_rise |-> !mem_we)
        else $error("array written between input edges");

    a_data_steady: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        !oc_rise && !ocn_rise |=> $stable(READ_PORT_BITS))
        else $error("read word changed between output edges");

    a_oe_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        READ_PORT_OE && !k_rise |=> READ_PORT_OE)
        else $error("outputs released away from an input rise");

    a_echo_comp: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        ocn_rise |=> ECHO_STROBE_PAIR[1])
        else $error("complement echo strobe not following output clock");

    a_strap_capture: assert property (@(posedge REF_CLK) disable iff (!RST_B || !CLK_EN)
        strap_cnt_q == dsb_pkg::STRAP_WAIT - dsb_pkg::STRAP_STEP
        |=> single_q == $past(pins_q.c & pins_q.c_n))
        else $error("single-pair strap not captured");

endmodule : dsb_sram_port

// ---- tb/dsb_ctrl_model.sv ----
// controller model for the sram port: commands, late-write beats, output pair straps
// assumes k is the free-running input pair clock and ref_clk the port's sampling clock
`timescale 1ns/1ps
module dsb_ctrl_model (
    // clocks and mode
    input wire logic ref_clk,
    input wire logic k,
    input wire logic sep_c,
    // pins toward the port
    output logic c_clk,
    output logic c_clk_n,
    output logic load_n,
    output logic rw,
    output logic [dsb_pkg::ADDR_W-1:0] addr,
    output logic [dsb_pkg::DATA_W-1:0] data,
    output logic [dsb_pkg::LANES-1:0] bw_n
);
    logic [79:0] wq[$];
    logic [79:0] b0;
    logic [79:0] b1;
    logic b0_ok;
    logic b1_ok;

    // both output pair pins held high selects single-pair mode
    assign c_clk = sep_c ? k : 1'b1;
    assign c_clk_n = sep_c ? ~k : 1'b1;

    // ==========================================================
    // command slot: changed mid half-period, held across the next k rise
    task automatic cmd(input logic rd, input logic [19:0] a, input logic [79:0] w);
        @(posedge k);
        repeat (2) @(negedge ref_clk);
        load_n = 1'b0;
        rw = rd;
        addr = a;
        if (!rd) wq.push_back(w);
    endtask : cmd

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge k);
            repeat (2) @(negedge ref_clk);
            load_n = 1'b1;
            rw = ~rw;
            addr = ~addr;
        end
    endtask : idle

    // ==========================================================
    // beats: first on the k rise after the command, second on the k# rise after that
    initial begin
        load_n = 1'b1;
        rw = 1'b0;
        addr = '0;
        data = '0;
        bw_n = 4'hF;
        b0_ok = 1'b0;
        b0 = '0;
        forever begin
            @(posedge k);
            b1_ok = b0_ok;
            b1 = b0;
            b0_ok = !load_n && !rw;
            if (b0_ok) b0 = wq.pop_front();
            repeat (2) @(negedge ref_clk);
            // idle beats carry toggling data and lanes that must be ignored
            data = b1_ok ? b1[39:4] : ~data;
            bw_n = b1_ok ? b1[3:0] : ~bw_n;
            @(negedge k);
            repeat (2) @(negedge ref_clk);
            data = b0_ok ? b0[79:44] : ~data;
            bw_n = b0_ok ? b0[43:40] : ~bw_n;
        end
    end
endmodule : dsb_ctrl_model

// ---- tb/dsb_sram_port_bench.sv ----
// self-checking bench for the sram port: writes, reads, lane masks, both output pair modes
// assumes the controller model drives the command and write pins
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dsb_sram_port_bench;
    logic ref_clk;
    logic rst_b;
    logic k;
    logic sep_c;
    logic ld_n;
    logic c_clk, c_clk_n, load_n, rw;
    logic [dsb_pkg::ADDR_W-1:0] addr;
    logic [dsb_pkg::DATA_W-1:0] data;
    logic [dsb_pkg::LANES-1:0] bw_n;
    logic [dsb_pkg::DATA_W-1:0] rd_bits;
    logic rd_oe;
    logic [1:0] echo;
    logic loop_act;
    int err_total;
    int samples_checked;
    int up_cnt;
    logic [31:0] lfsr_q = 32'hEF1B0858;
    logic [31:0] lt;
    logic [35:0] sh [int];
    logic [35:0] exp_q[$];
    logic [35:0] e;
    logic echo_q;
    logic [2:0] lhist;

    dsb_ctrl_model u_dsb_ctrl_model (.ref_clk(ref_clk), .k(k), .sep_c(sep_c), .c_clk(c_clk),
        .c_clk_n(c_clk_n), .load_n(load_n), .rw(rw), .addr(addr), .data(data), .bw_n(bw_n));
    dsb_sram_port u_dsb_sram_port (.REF_CLK(ref_clk), .RST_B(rst_b), .CLK_EN(1'b1),
        .K_CLK(k), .K_CLK_N(~k), .C_CLK(c_clk), .C_CLK_N(c_clk_n), .LOAD_N(load_n),
        .READ_WRITE_SELECT(rw), .ADDRESS_PINS(addr), .WRITE_PORT_BITS(data),
        .BYTE_LANE_WRITE_N(bw_n), .LOOP_DISABLE_N(ld_n), .READ_PORT_BITS(rd_bits),
        .READ_PORT_OE(rd_oe), .ECHO_STROBE_PAIR(echo), .LOOP_ACTIVE(loop_act));

    // ==========================================================
    // clocks: k is unrelated in phase to ref_clk
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        k = 1'b0;
        #37;
        forever #100 k = ~k;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd

    function automatic logic [35:0] r36();
        logic [31:0] hi;
        hi = rnd();
        return {hi[3:0], rnd()};
    endfunction : r36

    task automatic merge(input int idx, input logic [35:0] d, input logic [3:0] m);
        logic [35:0] w;
        w = sh.exists(idx) ? sh[idx] : 'x;
        for (int l = 0; l < 4; l++) if (!m[l]) w[9*l +: 9] = d[9*l +: 9];
        sh[idx] = w;
    endtask : merge

    task automatic wr(input logic [19:0] a, input logic [35:0] d0, input logic [3:0] m0,
                      input logic [35:0] d1, input logic [3:0] m1);
        merge(int'({a, 1'b0}), d0, m0);
        merge(int'({a, 1'b1}), d1, m1);
        u_dsb_ctrl_model.cmd(1'b0, a, {d0, m0, d1, m1});
    endtask : wr

    task automatic rd(input logic [19:0] a);
        exp_q.push_back(sh[int'({a, 1'b0})]);
        exp_q.push_back(sh[int'({a, 1'b1})]);
        u_dsb_ctrl_model.cmd(1'b1, a, '0);
    endtask : rd

    task automatic settle();
        u_dsb_ctrl_model.idle(3);
        @(posedge k);
        repeat (6) @(negedge ref_clk);
        `CHK(rd_oe, 1'b0)
        `CHK(exp_q.size(), 0)
    endtask : settle

    task automatic run_block(input string nm);
        logic [19:0] a [4];
        logic [31:0] t;
        for (int i = 0; i < 4; i++) begin
            t = rnd();
            a[i] = t[19:0];
        end
        for (int i = 0; i < 4; i++) wr(a[i], r36(), 4'h0, r36(), 4'h0);
        for (int i = 0; i < 4; i++) rd(a[i]);
        settle();
        // masked write then an immediate read of the same pair
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            wr(a[i % 4], r36(), t[3:0], r36(), t[7:4]);
            rd(a[i % 4]);
            settle();
        end
        $display("test %s done", nm);
    endtask : run_block

    task automatic do_reset();
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask : do_reset

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // ==========================================================
    // monitor: a word is due on every echo edge of a burst while the read port drives
    always @(negedge ref_clk) begin
        // the negative edge after a finished burst carries no word: the last one must hold
        if (rd_oe === 1'b1 && echo[0] !== echo_q) begin
            if (exp_q.size() != 0) begin
                e = exp_q.pop_front();
                `CHK(rd_bits, e)
            end else if (echo[0] === 1'b0) `CHK(rd_bits, e)
            else `CHK(1'b1, 1'b0)
        end
        echo_q = echo[0];
        up_cnt = rst_b ? up_cnt + 1 : 0;
        if (up_cnt > 4) `CHK(loop_act, lhist[1])
        lhist = {lhist[1:0], ld_n};
        lt = rnd();
        ld_n = lt[0];
    end

    // ==========================================================
    // main sequence and watchdog
    initial begin
        rst_b = 1'b0;
        sep_c = 1'b0;
        ld_n = 1'b1;
        err_total = 0;
        samples_checked = 0;
        up_cnt = 0;
        lhist = 3'h0;
        echo_q = 1'b0;
        do_reset();
        run_block("single pair");
        sep_c = 1'b1;
        do_reset();
        run_block("separate pair");
        final_report();
    end
    initial begin
        #300000;
        err_total++;
        $display("watchdog expired");
        final_report();
    end
endmodule : dsb_sram_port_bench
